// ---- eepg_consts.svh ----
`ifndef EEPG_CONSTS_SVH
`define EEPG_CONSTS_SVH

// ****************************************
// Address map
// ****************************************
`define EEPG_ARR_LO        16'h0800
`define EEPG_ARR_HI        16'h09ff
`define EEPG_NVCFG_ADDR    16'h0a10
`define EEPG_NVDIVH_ADDR   16'h0a11
`define EEPG_NVDIVL_ADDR   16'h0a12
`define EEPG_SEC_BLK       2'h1
`define EEPG_SEC_ROW       3'h7

// ****************************************
// Field positions
// ****************************************
`define EEPG_ARM_BIT       4
`define EEPG_LOCK_BIT      15
`define EEPG_DIV_MSB       10

// ****************************************
// Mode codes
// ****************************************
`define EEPG_MODE_PGM      2'h0
`define EEPG_MODE_BYTE     2'h1
`define EEPG_MODE_BLOCK    2'h2
`define EEPG_MODE_BULK     2'h3

// ****************************************
// Reset and factory values
// ****************************************
`define EEPG_ERASED        8'hff
`define EEPG_CFG_FACTORY   8'hf0
`define EEPG_DIV_FACTORY   16'h836b
`define EEPG_CFG_RST       8'hff
`define EEPG_DIV_RST       16'h0000

// ****************************************
// Timing
// ****************************************
`define EEPG_TICK_NS       35000
`define EEPG_CLK_NS        40
`define EEPG_TICK_CYC      (`EEPG_TICK_NS / `EEPG_CLK_NS)

`endif

// ---- eepg_pkg.sv ----
package eepg_pkg;

	typedef struct packed {
		logic [1:0] erase_mode;
		logic       auto_end;
		logic       latch;
		logic       hv;
	} eepg_ctl_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [7:0]  data;
	} eepg_acc_t;

	typedef enum logic [1:0] {
		EEPG_IDLE,
		EEPG_PULSE,
		EEPG_DWELL,
		EEPG_FALL
	} eepg_state_t;

endpackage

// ---- eepg_tick.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "eepg_consts.svh"

module eepg_tick (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [10:0] divisor,
	output logic             tick_ff
);

	logic [10:0] cnt_ff;
	logic [10:0] nxt_cnt;
	logic        nxt_tick;

	// Divisor of zero behaves as one so the timer never stalls
	always_comb begin
		nxt_cnt  = cnt_ff + 11'h001;
		nxt_tick = 1'b0;
		if (cnt_ff + 11'h001 >= divisor) begin
			nxt_cnt  = 11'h000;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff  <= 11'h000;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

endmodule // eepg_tick

`default_nettype wire

// ---- eepg_guard.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "eepg_consts.svh"

module eepg_guard
	import eepg_pkg::*;
#(
	parameter int unsigned PGM_TICKS   = 100,
	parameter int unsigned BYTE_TICKS  = 100,
	parameter int unsigned BLOCK_TICKS = 100,
	parameter int unsigned BULK_TICKS  = 100,
	parameter int unsigned FALL_TICKS  = 2
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire eepg_acc_t   acc_req,
	input  wire logic        ctl_wr,
	input  wire eepg_ctl_t   ctl_wdata,
	input  wire logic        div_wr,
	input  wire logic [15:0] div_wdata,
	output logic [7:0]       rd_data_ff,
	output logic             rd_valid_ff,
	output eepg_ctl_t        ctl_ff,
	output logic [7:0]       cfg_ff,
	output logic [15:0]      div_ff,
	output logic             cap_valid_ff,
	output logic             pump_on_ff,
	output logic             fail_ff
);

	// ****************************************
	// Nonvolatile storage
	// ****************************************
	// Factory content; no reset touches it since it must survive resets
	logic [7:0] mem [0:511] = '{default: `EEPG_ERASED};
	logic [7:0] nv_cfg      = `EEPG_CFG_FACTORY;
	logic [7:0] nv_divh     = 8'(`EEPG_DIV_FACTORY >> 8);
	logic [7:0] nv_divl     = 8'(`EEPG_DIV_FACTORY);

	// ****************************************
	// State
	// ****************************************
	eepg_state_t state_ff, nxt_state;
	eepg_ctl_t   nxt_ctl;
	logic [15:0] cap_addr_ff, nxt_cap_addr;
	logic [7:0]  cap_data_ff, nxt_cap_data;
	logic        nxt_cap_valid;
	logic [15:0] cnt_ff, nxt_cnt;
	logic        nxt_fail;
	logic [7:0]  nxt_rd_data;
	logic        nxt_rd_valid;
	logic [7:0]  nxt_cfg;
	logic [15:0] nxt_div;
	logic        load_ff;
	logic        nxt_pump;
	logic        tick;

	eepg_tick u_tick (
		.clk     (clk),
		.rst     (rst),
		.divisor (div_ff[`EEPG_DIV_MSB:0]),
		.tick_ff (tick)
	);

	// ****************************************
	// Address classification
	// ****************************************
	function automatic logic in_array(input logic [15:0] a);
		return (a >= `EEPG_ARR_LO) && (a <= `EEPG_ARR_HI);
	endfunction

	function automatic logic is_valid(input logic [15:0] a);
		return in_array(a) || a == `EEPG_NVCFG_ADDR || a == `EEPG_NVDIVH_ADDR
			|| a == `EEPG_NVDIVL_ADDR;
	endfunction

	logic       armed;
	logic       div_locked;
	logic [1:0] cap_blk;
	logic       cap_secured;
	logic       cap_arr;
	logic       perm_ok;
	logic       do_commit;
	logic [15:0] tgt_ticks;
	logic       acc_rd;
	logic       acc_wr;

	assign armed       = ~nv_cfg[`EEPG_ARM_BIT] | ~cfg_ff[`EEPG_ARM_BIT];
	assign div_locked  = ~div_ff[`EEPG_LOCK_BIT];
	assign cap_blk     = cap_addr_ff[8:7];
	assign cap_arr     = in_array(cap_addr_ff);
	assign cap_secured = cap_arr && cap_blk == `EEPG_SEC_BLK
		&& cap_addr_ff[6:4] == `EEPG_SEC_ROW;
	assign acc_rd      = acc_req.valid && !acc_req.write && is_valid(acc_req.addr);
	assign acc_wr      = acc_req.valid && acc_req.write && is_valid(acc_req.addr);

	// Guard decision for the captured target
	always_comb begin
		perm_ok = 1'b0;
		if (cap_arr) begin
			if (ctl_ff.erase_mode == `EEPG_MODE_PGM || ctl_ff.erase_mode == `EEPG_MODE_BYTE) begin
				perm_ok = !cfg_ff[cap_blk] && !(armed && cap_secured);
			end else if (ctl_ff.erase_mode == `EEPG_MODE_BLOCK) begin
				perm_ok = !armed && !cfg_ff[cap_blk];
			end else begin
				perm_ok = !armed;
			end
		end else if (cap_addr_ff == `EEPG_NVCFG_ADDR) begin
			perm_ok = !armed && ctl_ff.erase_mode[1] == 1'b0;
		end else begin
			perm_ok = !div_locked && ctl_ff.erase_mode[1] == 1'b0;
		end
	end

	always_comb begin
		if (ctl_ff.erase_mode == `EEPG_MODE_PGM) begin
			tgt_ticks = 16'(PGM_TICKS);
		end else if (ctl_ff.erase_mode == `EEPG_MODE_BYTE) begin
			tgt_ticks = 16'(BYTE_TICKS);
		end else if (ctl_ff.erase_mode == `EEPG_MODE_BLOCK) begin
			tgt_ticks = 16'(BLOCK_TICKS);
		end else begin
			tgt_ticks = 16'(BULK_TICKS);
		end
		// Self-timed end lands one tick short of the nominal pulse
		if (ctl_ff.auto_end) begin
			tgt_ticks = tgt_ticks - 16'h0001;
		end
	end

	// ****************************************
	// Control, capture and sequencer
	// ****************************************
	logic pulse_done;
	assign pulse_done = state_ff == EEPG_PULSE && tick && cnt_ff + 16'h0001 >= tgt_ticks;
	assign do_commit  = pulse_done && perm_ok && !fail_ff;

	always_comb begin
		nxt_state     = state_ff;
		nxt_ctl       = ctl_ff;
		nxt_cap_addr  = cap_addr_ff;
		nxt_cap_data  = cap_data_ff;
		nxt_cap_valid = cap_valid_ff;
		nxt_cnt       = cnt_ff;
		nxt_fail      = fail_ff;
		nxt_rd_valid  = acc_rd;
		nxt_rd_data   = `EEPG_ERASED;
		nxt_cfg       = cfg_ff;
		nxt_div       = div_ff;

		if (acc_rd) begin
			if (ctl_ff.latch) begin
				nxt_rd_data  = cap_data_ff;
				nxt_cap_addr = acc_req.addr;
			end else if (in_array(acc_req.addr)) begin
				nxt_rd_data = mem[acc_req.addr[8:0]];
			end else if (acc_req.addr == `EEPG_NVCFG_ADDR) begin
				nxt_rd_data = nv_cfg;
				nxt_cfg     = nv_cfg;
			end else if (acc_req.addr == `EEPG_NVDIVH_ADDR) begin
				nxt_rd_data = nv_divh;
			end else begin
				nxt_rd_data = nv_divl;
			end
			// A read under high voltage spoils the running cycle
			if (ctl_ff.hv) begin
				nxt_fail = 1'b1;
			end
		end

		if (acc_wr && ctl_ff.latch && !ctl_ff.hv) begin
			nxt_cap_addr  = acc_req.addr;
			nxt_cap_data  = acc_req.data;
			nxt_cap_valid = 1'b1;
		end

		if (load_ff) begin
			nxt_cfg = nv_cfg;
			nxt_div = {nv_divh, nv_divl};
		end else if (div_wr && !ctl_ff.latch && !div_locked) begin
			nxt_div = div_wdata;
		end

		if (ctl_wr && !(ctl_ff.latch && !cap_valid_ff)) begin
			if (ctl_ff.hv) begin
				if (!ctl_wdata.hv) begin
					nxt_ctl.hv = 1'b0;
					nxt_state  = EEPG_FALL;
					nxt_cnt    = 16'h0000;
				end
			end else begin
				nxt_ctl.erase_mode = ctl_wdata.erase_mode;
				nxt_ctl.auto_end   = ctl_wdata.auto_end;
				nxt_ctl.latch      = ctl_wdata.latch;
				// Capture in the same cycle as a latch drop wins over the clear
				if ((ctl_wdata.latch && !ctl_ff.latch) || (!ctl_wdata.latch && !acc_wr)) begin
					nxt_cap_valid = 1'b0;
				end
				if (ctl_wdata.hv && ctl_ff.latch && cap_valid_ff && ctl_wdata.latch) begin
					nxt_ctl.hv = 1'b1;
					nxt_state  = EEPG_PULSE;
					nxt_cnt    = 16'h0000;
					nxt_fail   = 1'b0;
				end
			end
		end

		case (state_ff)
			EEPG_PULSE: begin
				if (tick) begin
					nxt_cnt = cnt_ff + 16'h0001;
				end
				if (pulse_done && nxt_ctl.hv) begin
					nxt_cnt = 16'h0000;
					if (ctl_ff.auto_end) begin
						nxt_ctl.hv = 1'b0;
						nxt_state  = EEPG_FALL;
					end else begin
						nxt_state = EEPG_DWELL;
					end
				end
			end
			EEPG_FALL: begin
				if (tick) begin
					nxt_cnt = cnt_ff + 16'h0001;
					if (cnt_ff + 16'h0001 >= 16'(FALL_TICKS)) begin
						nxt_state = EEPG_IDLE;
					end
				end
			end
			default: begin
			end
		endcase
		nxt_pump = nxt_state != EEPG_IDLE;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff     <= EEPG_IDLE;
			ctl_ff       <= '0;
			cap_addr_ff  <= 16'h0000;
			cap_data_ff  <= 8'h00;
			cap_valid_ff <= 1'b0;
			cnt_ff       <= 16'h0000;
			fail_ff      <= 1'b0;
			rd_data_ff   <= 8'h00;
			rd_valid_ff  <= 1'b0;
			cfg_ff       <= `EEPG_CFG_RST;
			div_ff       <= `EEPG_DIV_RST;
			load_ff      <= 1'b1;
			pump_on_ff   <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			ctl_ff       <= nxt_ctl;
			cap_addr_ff  <= nxt_cap_addr;
			cap_data_ff  <= nxt_cap_data;
			cap_valid_ff <= nxt_cap_valid;
			cnt_ff       <= nxt_cnt;
			fail_ff      <= nxt_fail;
			rd_data_ff   <= nxt_rd_data;
			rd_valid_ff  <= nxt_rd_valid;
			cfg_ff       <= nxt_cfg;
			div_ff       <= nxt_div;
			load_ff      <= 1'b0;
			pump_on_ff   <= nxt_pump;
		end
	end

	// ****************************************
	// Array update
	// ****************************************
	// Bulk skips guarded blocks instead of refusing the whole array
	always_ff @(posedge clk) begin
		if (do_commit) begin
			if (ctl_ff.erase_mode == `EEPG_MODE_PGM) begin
				if (cap_arr) begin
					mem[cap_addr_ff[8:0]] <= mem[cap_addr_ff[8:0]] & cap_data_ff;
				end else if (cap_addr_ff == `EEPG_NVCFG_ADDR) begin
					nv_cfg <= nv_cfg & cap_data_ff;
				end else if (cap_addr_ff == `EEPG_NVDIVH_ADDR) begin
					nv_divh <= nv_divh & cap_data_ff;
				end else begin
					nv_divl <= nv_divl & cap_data_ff;
				end
			end else if (ctl_ff.erase_mode == `EEPG_MODE_BYTE) begin
				if (cap_arr) begin
					mem[cap_addr_ff[8:0]] <= `EEPG_ERASED;
				end else if (cap_addr_ff == `EEPG_NVCFG_ADDR) begin
					nv_cfg <= `EEPG_ERASED;
				end else if (cap_addr_ff == `EEPG_NVDIVH_ADDR) begin
					nv_divh <= `EEPG_ERASED;
				end else begin
					nv_divl <= `EEPG_ERASED;
				end
			end else begin
				for (int i = 0; i < 512; i++) begin
					if (!cfg_ff[i / 128] && (ctl_ff.erase_mode == `EEPG_MODE_BULK
						|| (i / 128) == int'(cap_blk))) begin
						mem[i] <= `EEPG_ERASED;
					end
				end
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_hv_needs_capture;
		@(posedge clk) disable iff (rst)
		$rose(ctl_ff.hv) |-> $past(ctl_ff.latch) && $past(cap_valid_ff);
	endproperty
	a_hv_needs_capture: assert property (p_hv_needs_capture) else $error("hv no latch");

	property p_latch_kept;
		@(posedge clk) disable iff (rst)
		ctl_ff.hv && ctl_wr && cap_valid_ff && !ctl_wdata.hv && !ctl_wdata.latch
			|=> !ctl_ff.hv && ctl_ff.latch;
	endproperty
	a_latch_kept: assert property (p_latch_kept) else $error("latch dropped with hv");

	property p_no_block_armed;
		@(posedge clk) disable iff (rst)
		do_commit && armed |-> ctl_ff.erase_mode[1] == 1'b0;
	endproperty
	a_no_block_armed: assert property (p_no_block_armed) else $error("armed erase ran");

	property p_secured;
		@(posedge clk) disable iff (rst)
		do_commit && armed |-> !cap_secured && cap_addr_ff != `EEPG_NVCFG_ADDR;
	endproperty
	a_secured: assert property (p_secured) else $error("secured byte altered");

	property p_guarded;
		@(posedge clk) disable iff (rst)
		do_commit && cap_arr && ctl_ff.erase_mode != `EEPG_MODE_BULK |-> !cfg_ff[cap_blk];
	endproperty
	a_guarded: assert property (p_guarded) else $error("guarded block altered");

	property p_div_locked;
		@(posedge clk) disable iff (rst)
		div_locked && !load_ff |=> $stable(div_ff);
	endproperty
	a_div_locked: assert property (p_div_locked) else $error("locked divider changed");

	property p_auto_end;
		@(posedge clk) disable iff (rst)
		pulse_done && ctl_ff.auto_end && ctl_ff.hv |=> !ctl_ff.hv && state_ff == EEPG_FALL;
	endproperty
	a_auto_end: assert property (p_auto_end) else $error("auto end missed");

	property p_latched_read;
		@(posedge clk) disable iff (rst)
		acc_rd && ctl_ff.latch |=> rd_valid_ff && rd_data_ff == $past(cap_data_ff)
			&& cap_addr_ff == $past(acc_req.addr);
	endproperty
	a_latched_read: assert property (p_latched_read) else $error("latched read wrong");

	property p_capture_last;
		@(posedge clk) disable iff (rst)
		acc_wr && ctl_ff.latch && !ctl_ff.hv |=> cap_valid_ff && cap_data_ff == $past(acc_req.data);
	endproperty
	a_capture_last: assert property (p_capture_last) else $error("capture not latest");

	property p_ctl_wait;
		@(posedge clk) disable iff (rst)
		ctl_ff.latch && !cap_valid_ff && !acc_wr |=> $stable(ctl_ff);
	endproperty
	a_ctl_wait: assert property (p_ctl_wait) else $error("early control write");

	c_program: cover property (@(posedge clk) do_commit && ctl_ff.erase_mode == `EEPG_MODE_PGM);
	c_bulk: cover property (@(posedge clk) do_commit && ctl_ff.erase_mode == `EEPG_MODE_BULK);
	c_fail: cover property (@(posedge clk) $rose(fail_ff));
	c_auto: cover property (@(posedge clk) pulse_done && ctl_ff.auto_end);

endmodule // eepg_guard

`default_nettype wire

// ---- tb_eeprom_program_erase_guard.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "eepg_consts.svh"

module tb_eeprom_program_erase_guard
	import eepg_pkg::*;
;
	localparam int unsigned P_TICKS = 3;

	logic        clk;
	logic        rst;
	eepg_acc_t   acc_req;
	logic        ctl_wr;
	eepg_ctl_t   ctl_wdata;
	logic        div_wr;
	logic [15:0] div_wdata;
	logic [7:0]  rd_data_ff;
	logic        rd_valid_ff;
	eepg_ctl_t   ctl_ff;
	logic [7:0]  cfg_ff;
	logic [15:0] div_ff;
	logic        cap_valid_ff;
	logic        pump_on_ff;
	logic        fail_ff;
	int          n_mismatch;
	int          compares;

	eepg_guard #(
		.PGM_TICKS   (P_TICKS),
		.BYTE_TICKS  (P_TICKS),
		.BLOCK_TICKS (P_TICKS),
		.BULK_TICKS  (P_TICKS),
		.FALL_TICKS  (2)
	) u_dut (
		.clk          (clk),
		.rst          (rst),
		.acc_req      (acc_req),
		.ctl_wr       (ctl_wr),
		.ctl_wdata    (ctl_wdata),
		.div_wr       (div_wr),
		.div_wdata    (div_wdata),
		.rd_data_ff   (rd_data_ff),
		.rd_valid_ff  (rd_valid_ff),
		.ctl_ff       (ctl_ff),
		.cfg_ff       (cfg_ff),
		.div_ff       (div_ff),
		.cap_valid_ff (cap_valid_ff),
		.pump_on_ff   (pump_on_ff),
		.fail_ff      (fail_ff)
	);

	// ****************************************
	// Clock and shared tasks
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic do_reset();
		rst = 1'b1;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		// Nonvolatile copies land on the first edge after release
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic ctl(input logic [1:0] m, input logic a, input logic l, input logic h);
		@(posedge clk);
		#1;
		ctl_wr = 1'b1;
		ctl_wdata = {m, a, l, h};
		@(posedge clk);
		#1;
		ctl_wr = 1'b0;
	endtask

	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		acc_req = {1'b1, w, a, d};
		@(posedge clk);
		#1;
		acc_req.valid = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk({15'h0000, rd_valid_ff}, 16'h0001);
		chk({8'h00, rd_data_ff}, {8'h00, exp});
	endtask

	task automatic divw(input logic [15:0] v);
		@(posedge clk);
		#1;
		div_wr = 1'b1;
		div_wdata = v;
		@(posedge clk);
		#1;
		div_wr = 1'b0;
	endtask

	task automatic wait_pump();
		int n;
		n = 0;
		while (pump_on_ff !== 1'b0 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({15'h0000, pump_on_ff}, 16'h0000);
	endtask

	// Full self-timed sequence; polls the enable as software would
	task automatic op(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d);
		int n;
		ctl(m, 1'b1, 1'b1, 1'b0);
		acc(1'b1, a, d);
		ctl(m, 1'b1, 1'b1, 1'b1);
		n = 0;
		while (ctl_ff.hv === 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({15'h0000, n < P_TICKS}, 16'h0001);
		wait_pump();
		ctl(m, 1'b0, 1'b0, 1'b0);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_program();
		rd(16'h0800, `EEPG_ERASED);
		op(`EEPG_MODE_PGM, 16'h0800, 8'hfe);
		// Second pattern only clears a bit still at one
		op(`EEPG_MODE_PGM, 16'h0800, 8'hfd);
		rd(16'h0800, 8'hfc);
	endtask

	task automatic s_erase();
		op(`EEPG_MODE_BLOCK, 16'h087f, 8'h3c);
		rd(16'h0800, 8'hff);
		op(`EEPG_MODE_PGM, 16'h0900, 8'h0f);
		op(`EEPG_MODE_BULK, 16'h0800, 8'h00);
		rd(16'h0900, 8'hff);
		op(`EEPG_MODE_PGM, 16'h0980, 8'h00);
		op(`EEPG_MODE_BYTE, 16'h0980, 8'h00);
		rd(16'h0980, 8'hff);
		op(`EEPG_MODE_PGM, 16'h0800, 8'h55);
	endtask

	task automatic s_refuse();
		ctl(`EEPG_MODE_PGM, 1'b0, 1'b1, 1'b0);
		acc(1'b1, 16'h0700, 8'h00);
		chk({15'h0000, cap_valid_ff}, 16'h0000);
		ctl(`EEPG_MODE_PGM, 1'b0, 1'b1, 1'b1);
		chk({15'h0000, ctl_ff.hv}, 16'h0000);
		// Latch cannot drop until a valid write has been captured
		ctl(`EEPG_MODE_PGM, 1'b0, 1'b0, 1'b0);
		chk({15'h0000, ctl_ff.latch}, 16'h0001);
		acc(1'b1, 16'h0802, 8'hff);
		chk({15'h0000, cap_valid_ff}, 16'h0001);
		ctl(`EEPG_MODE_PGM, 1'b0, 1'b0, 1'b0);
		chk({15'h0000, ctl_ff.latch}, 16'h0000);
	endtask

	task automatic s_abort();
		ctl(`EEPG_MODE_PGM, 1'b0, 1'b1, 1'b0);
		acc(1'b1, 16'h0801, 8'h11);
		acc(1'b1, 16'h0801, 8'h00);
		ctl(`EEPG_MODE_PGM, 1'b0, 1'b1, 1'b1);
		chk({15'h0000, pump_on_ff}, 16'h0001);
		rd(16'h0801, 8'h00);
		@(posedge clk);
		#1;
		chk({15'h0000, fail_ff}, 16'h0001);
		ctl(`EEPG_MODE_PGM, 1'b0, 1'b0, 1'b0);
		chk({14'h0000, ctl_ff.latch, ctl_ff.hv}, 16'h0002);
		wait_pump();
		ctl(`EEPG_MODE_PGM, 1'b0, 1'b0, 1'b0);
		rd(16'h0801, 8'hff);
	endtask

	// Manual end: enable holds through the dwell until software drops it
	task automatic s_manual();
		ctl(`EEPG_MODE_PGM, 1'b0, 1'b1, 1'b0);
		acc(1'b1, 16'h0802, 8'hf7);
		ctl(`EEPG_MODE_PGM, 1'b0, 1'b1, 1'b1);
		repeat (P_TICKS + 1) @(posedge clk);
		#1;
		chk({15'h0000, ctl_ff.hv}, 16'h0001);
		ctl(`EEPG_MODE_PGM, 1'b0, 1'b1, 1'b0);
		wait_pump();
		ctl(`EEPG_MODE_PGM, 1'b0, 1'b0, 1'b0);
		rd(16'h0802, 8'hf7);
	endtask

	task automatic s_guard();
		op(`EEPG_MODE_BYTE, `EEPG_NVCFG_ADDR, 8'h00);
		rd(`EEPG_NVCFG_ADDR, 8'hff);
		chk({8'h00, cfg_ff}, 16'h00ff);
		op(`EEPG_MODE_PGM, 16'h0900, 8'h00);
		rd(16'h0900, 8'hff);
		op(`EEPG_MODE_PGM, `EEPG_NVCFG_ADDR, 8'hf0);
		rd(`EEPG_NVCFG_ADDR, 8'hf0);
		chk({8'h00, cfg_ff}, 16'h00f0);
	endtask

	task automatic s_arm();
		op(`EEPG_MODE_PGM, `EEPG_NVCFG_ADDR, 8'hef);
		rd(`EEPG_NVCFG_ADDR, 8'he0);
		op(`EEPG_MODE_PGM, 16'h08f0, 8'h00);
		rd(16'h08f0, 8'hff);
		op(`EEPG_MODE_BLOCK, 16'h0800, 8'h00);
		rd(16'h0800, 8'h55);
		op(`EEPG_MODE_BULK, 16'h0900, 8'h00);
		rd(16'h0800, 8'h55);
		op(`EEPG_MODE_PGM, 16'h0801, 8'h0f);
		rd(16'h0801, 8'h0f);
		op(`EEPG_MODE_BYTE, 16'h0800, 8'h00);
		rd(16'h0800, 8'hff);
		op(`EEPG_MODE_BYTE, `EEPG_NVCFG_ADDR, 8'h00);
		rd(`EEPG_NVCFG_ADDR, 8'he0);
	endtask

	task automatic s_lock();
		op(`EEPG_MODE_PGM, `EEPG_NVDIVH_ADDR, 8'h7f);
		do_reset();
		chk(div_ff, 16'h036b);
		divw(16'h8001);
		chk(div_ff, 16'h036b);
		chk({8'h00, cfg_ff}, 16'h00e0);
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		n_mismatch = 0;
		compares = 0;
		rst = 1'b1;
		acc_req = '0;
		ctl_wr = 1'b0;
		ctl_wdata = '0;
		div_wr = 1'b0;
		div_wdata = 16'h0000;
		do_reset();
		chk({8'h00, cfg_ff}, {8'h00, `EEPG_CFG_FACTORY});
		chk(div_ff, `EEPG_DIV_FACTORY);
		chk({11'h000, ctl_ff}, 16'h0000);
		// One timebase tick per clock keeps pulses short
		divw(16'h8001);
		chk(div_ff, 16'h8001);
		s_program();
		s_erase();
		s_refuse();
		s_abort();
		s_manual();
		s_guard();
		s_arm();
		s_lock();
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end

endmodule // tb_eeprom_program_erase_guard

`default_nettype wire
